// ### rtl/ddrrp_pkg.sv
// Shared widths, command codes and state types of the native read port
package ddrrp_pkg;
  // Native port widths
  localparam int ADDR_W = 27;
  localparam int DATA_W = 32;
  localparam int SIZE_W = 6;
  // Default address split: row, bank, column from high to low
  localparam int COL_W = 10;
  localparam int BANK_W = 3;
  localparam int ROW_W = 14;
  // Address pin carrying the auto-precharge request on a read
  localparam int AP_BIT = 10;
  // Command spacing: one memory command per this many cycles
  localparam int CMD_GAP = 4;
  localparam int GAP_W = 2;
  localparam logic [GAP_W-1:0] GAP_RELOAD = GAP_W'(CMD_GAP - 1);
  // Host run length counter width
  localparam int CNT_W = 8;
  // Memory command bus codes
  typedef enum logic [2:0] {
    CMD_NOP,
    CMD_ACT,
    CMD_RD,
    CMD_RDA,
    CMD_PRE
  } ddrrp_cmd_t;
  // Device end states
  typedef enum logic [2:0] {
    DS_IDLE,
    DS_PLAN,
    DS_PRE,
    DS_ACT,
    DS_RD,
    DS_DATA
  } ddrrp_dstate_t;
  // Host end states
  typedef enum logic [1:0] {
    HS_IDLE,
    HS_REQ,
    HS_DRAIN
  } ddrrp_hstate_t;
endpackage

// ### rtl/ddrrp_if.sv
// Native read request interface joining user logic and the memory subsystem
`timescale 1ns/100ps
interface ddrrp_if import ddrrp_pkg::*; ();
  logic reqRead;
  logic reqWrite;
  logic [ADDR_W-1:0] reqAddr;
  logic [SIZE_W-1:0] reqSize;
  logic autoPrechargeFlag;
  logic stall;
  logic readValid;
  logic [DATA_W-1:0] readDataBus;

  // Memory subsystem end
  modport dev (
    input reqRead, reqWrite, reqAddr, reqSize, autoPrechargeFlag,
    output stall, readValid, readDataBus
  );
  // User logic end
  modport host (
    output reqRead, reqWrite, reqAddr, reqSize, autoPrechargeFlag,
    input stall, readValid, readDataBus
  );
endinterface

// ### rtl/ddrrp_device.sv
// Memory subsystem end: accepts native reads and drives memory commands
`timescale 1ns/100ps

// Summary of operation
// - Requester drives strobe, address, size together
// - Auto-precharge flag turns read into read-precharge
// - Request taken when strobe high, stall low
// - Strobe may stay high for cascaded requests
// - Address, size, flag sampled only while stall low
// - Size and flag may be held constant
// - Read strobe never high with write strobe
// - Valid marks exactly cycles with read data
// - No fixed timing among request, stall, valid
// - Requester drops strobe when nothing left
// - Closed row opened by activate with row, bank
// - One read command with column per request
// - Data seen on memory lines before native bus
// - Precharge or activate before read when needed
// - Memory commands spaced four cycles apart
module ddrrp_device import ddrrp_pkg::*; #(
  parameter int COLW = COL_W,
  parameter int BANKW = BANK_W,
  parameter int ROWW = ROW_W
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Native port
  ddrrp_if.dev nat,
  // Memory command bus
  output ddrrp_cmd_t memCmd,
  output logic memCsN,
  output logic [ROWW-1:0] memAddr,
  output logic [BANKW-1:0] memBank,
  // Memory read data lines
  input wire logic [DATA_W-1:0] memDq,
  input wire logic memDqValid
);

  // Refuse address splits the port cannot serve
  if (COLW + BANKW + ROWW != ADDR_W || ROWW <= AP_BIT || COLW > AP_BIT) begin : g_chk
    $error("ddrrp_device: address split does not fit the port");
  end

  typedef struct packed {
    ddrrp_dstate_t state;
    logic stall;
    logic [ROWW-1:0] row;
    logic [BANKW-1:0] bank;
    logic [COLW-1:0] col;
    logic ap;
    logic [SIZE_W-1:0] beats;
    logic [GAP_W-1:0] gap;
    logic openValid;
    logic [ROWW-1:0] openRow;
    logic [BANKW-1:0] openBank;
    ddrrp_cmd_t cmd;
    logic csN;
    logic [ROWW-1:0] pinAddr;
    logic [BANKW-1:0] pinBank;
    logic rdValid;
    logic [DATA_W-1:0] rdData;
  } ddrrp_dev_st_t;

  ddrrp_dev_st_t st_ff;
  ddrrp_dev_st_t nxt_st;
  logic gapFree;
  logic takeReq;

  // Column placed on the address pins, precharge bit beside it
  function automatic logic [ROWW-1:0] ddrrp_col_pins(input logic [COLW-1:0] col,
                                                   input logic ap);
    logic [ROWW-1:0] pins;
    pins = '0;
    pins[COLW-1:0] = col;
    pins[AP_BIT] = ap;
    return pins;
  endfunction

  // Command slot and request acceptance
  assign gapFree = (st_ff.gap == '0);
  assign takeReq = nat.reqRead && !nat.reqWrite && !st_ff.stall;

  // Next state of the whole port
  always_comb begin
    nxt_st = st_ff;
    nxt_st.cmd = CMD_NOP;
    nxt_st.csN = 1'b1;
    nxt_st.rdValid = 1'b0;
    if (!gapFree) begin
      nxt_st.gap = st_ff.gap - GAP_W'(1);
    end
    case (st_ff.state)
      DS_IDLE: begin
        nxt_st.stall = 1'b0;
        if (takeReq) begin
          // Inputs captured only in the accepting cycle
          nxt_st.col = nat.reqAddr[COLW-1:0];
          nxt_st.bank = nat.reqAddr[COLW +: BANKW];
          nxt_st.row = nat.reqAddr[COLW+BANKW +: ROWW];
          nxt_st.ap = nat.autoPrechargeFlag;
          nxt_st.beats = (nat.reqSize == '0) ? SIZE_W'(1) : nat.reqSize;
          nxt_st.stall = 1'b1;
          nxt_st.state = DS_PLAN;
        end
      end
      DS_PLAN: begin
        if (!st_ff.openValid) begin
          nxt_st.state = DS_ACT;
        end else if (st_ff.openBank == st_ff.bank && st_ff.openRow == st_ff.row) begin
          nxt_st.state = DS_RD;
        end else begin
          nxt_st.state = DS_PRE;
        end
      end
      DS_PRE: begin
        if (gapFree) begin
          // Close the open row before another is opened
          nxt_st.cmd = CMD_PRE;
          nxt_st.csN = 1'b0;
          nxt_st.pinAddr = '0;
          nxt_st.pinBank = st_ff.openBank;
          nxt_st.openValid = 1'b0;
          nxt_st.gap = GAP_RELOAD;
          nxt_st.state = DS_ACT;
        end
      end
      DS_ACT: begin
        if (gapFree) begin
          // Open requested row in requested bank
          nxt_st.cmd = CMD_ACT;
          nxt_st.csN = 1'b0;
          nxt_st.pinAddr = st_ff.row;
          nxt_st.pinBank = st_ff.bank;
          nxt_st.openValid = 1'b1;
          nxt_st.openRow = st_ff.row;
          nxt_st.openBank = st_ff.bank;
          nxt_st.gap = GAP_RELOAD;
          nxt_st.state = DS_RD;
        end
      end
      DS_RD: begin
        if (gapFree) begin
          // Single read command carrying the column
          nxt_st.cmd = st_ff.ap ? CMD_RDA : CMD_RD;
          nxt_st.csN = 1'b0;
          nxt_st.pinAddr = ddrrp_col_pins(st_ff.col, st_ff.ap);
          nxt_st.pinBank = st_ff.bank;
          if (st_ff.ap) begin
            nxt_st.openValid = 1'b0;
          end
          nxt_st.gap = GAP_RELOAD;
          nxt_st.state = DS_DATA;
        end
      end
      DS_DATA: begin
        // Memory data forwarded one cycle later, in order
        nxt_st.rdValid = memDqValid;
        if (memDqValid) begin
          nxt_st.rdData = memDq;
          nxt_st.beats = st_ff.beats - SIZE_W'(1);
          if (st_ff.beats == SIZE_W'(1)) begin
            nxt_st.stall = 1'b0;
            nxt_st.state = DS_IDLE;
          end
        end
      end
      default: begin
        nxt_st.state = DS_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      st_ff <= '0;
      st_ff.csN <= 1'b1;
      st_ff.state <= DS_IDLE;
      st_ff.cmd <= CMD_NOP;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the state register
  assign nat.stall = st_ff.stall;
  assign nat.readValid = st_ff.rdValid;
  assign nat.readDataBus = st_ff.rdData;
  assign memCmd = st_ff.cmd;
  assign memCsN = st_ff.csN;
  assign memAddr = st_ff.pinAddr;
  assign memBank = st_ff.pinBank;

endmodule

// ### rtl/ddrrp_host.sv
// User logic end: issues a run of cascaded reads and collects the data
`timescale 1ns/100ps
module ddrrp_host import ddrrp_pkg::*; #(
  parameter int CNTW = CNT_W
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Native port
  ddrrp_if.host nat,
  // Run command
  input wire logic runStart,
  input wire logic [ADDR_W-1:0] runAddr,
  input wire logic [CNTW-1:0] runCount,
  input wire logic [SIZE_W-1:0] runSize,
  input wire logic runAutoPre,
  // Run status and data
  output logic runBusy,
  output logic runDone,
  output logic userValid,
  output logic [DATA_W-1:0] userData
);

  // Refuse a counter that cannot hold a request
  if (CNTW < 1) begin : g_chk
    $error("ddrrp_host: CNTW must be at least 1");
  end

  localparam int DUE_W = CNTW + SIZE_W;

  typedef struct packed {
    ddrrp_hstate_t state;
    logic req;
    logic [ADDR_W-1:0] addr;
    logic [SIZE_W-1:0] size;
    logic ap;
    logic [CNTW-1:0] left;
    logic [DUE_W-1:0] due;
    logic busy;
    logic done;
    logic valid;
    logic [DATA_W-1:0] data;
  } ddrrp_host_st_t;

  ddrrp_host_st_t st_ff;
  ddrrp_host_st_t nxt_st;
  logic taken;
  logic [SIZE_W-1:0] beatsPer;

  // Request taken by the far end this cycle
  assign taken = st_ff.req && !nat.stall;
  assign beatsPer = (st_ff.size == '0) ? SIZE_W'(1) : st_ff.size;

  // Next state of the run
  always_comb begin
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    nxt_st.valid = nat.readValid;
    if (nat.readValid) begin
      nxt_st.data = nat.readDataBus;
    end
    nxt_st.due = st_ff.due + (taken ? DUE_W'(beatsPer) : '0)
                 - (nat.readValid ? DUE_W'(1) : '0);
    case (st_ff.state)
      HS_IDLE: begin
        if (runStart && runCount != '0) begin
          // Strobe, address and size raised together
          nxt_st.req = 1'b1;
          nxt_st.addr = runAddr;
          nxt_st.size = runSize;
          nxt_st.ap = runAutoPre;
          nxt_st.left = runCount;
          nxt_st.busy = 1'b1;
          nxt_st.state = HS_REQ;
        end
      end
      HS_REQ: begin
        if (taken) begin
          // Next address presented while strobe stays high
          nxt_st.addr = st_ff.addr + ADDR_W'(beatsPer);
          nxt_st.left = st_ff.left - CNTW'(1);
          if (st_ff.left == CNTW'(1)) begin
            nxt_st.req = 1'b0;
            nxt_st.state = HS_DRAIN;
          end
        end
      end
      HS_DRAIN: begin
        if (nxt_st.due == '0) begin
          nxt_st.busy = 1'b0;
          nxt_st.done = 1'b1;
          nxt_st.state = HS_IDLE;
        end
      end
      default: begin
        nxt_st.state = HS_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      st_ff <= '0;
      st_ff.state <= HS_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Write strobe tied low, other outputs straight from the state register
  assign nat.reqRead = st_ff.req;
  assign nat.reqWrite = 1'b0;
  assign nat.reqAddr = st_ff.addr;
  assign nat.reqSize = st_ff.size;
  assign nat.autoPrechargeFlag = st_ff.ap;
  assign runBusy = st_ff.busy;
  assign runDone = st_ff.done;
  assign userValid = st_ff.valid;
  assign userData = st_ff.data;

endmodule

// ### verif/ddrrp_checker.sv
// Protocol checks on the native read interface
`timescale 1ns/100ps
module ddrrp_checker import ddrrp_pkg::*; (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Native port
  input wire logic reqRead,
  input wire logic reqWrite,
  input wire logic [ADDR_W-1:0] reqAddr,
  input wire logic [SIZE_W-1:0] reqSize,
  input wire logic autoPrechargeFlag,
  input wire logic stall,
  input wire logic readValid,
  input wire logic [DATA_W-1:0] readDataBus
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // Accept handshake
  chk_accept_stall: assert property (reqRead && !reqWrite && !stall |=> stall)
    else $error("stall not raised after accept");
  chk_no_write: assert property (!reqWrite)
    else $error("write strobe raised on read port");
  // Request values held while refused
  chk_req_hold: assert property (reqRead && stall |=>
    reqRead && $stable({reqAddr, reqSize, autoPrechargeFlag}))
    else $error("request changed while stalled");
  // Cascaded requests step by burst length
  chk_addr_step: assert property ((reqRead && !stall) ##1 reqRead |->
    reqAddr == $past(reqAddr) + ADDR_W'(($past(reqSize) == 0) ? 1 : $past(reqSize)))
    else $error("cascaded address step wrong");
  chk_drop_taken: assert property ($fell(reqRead) && $past(resetn) |->
    $past(reqRead && !stall))
    else $error("strobe dropped before request taken");
  // Data beats only inside a busy request
  chk_valid_busy: assert property (readValid |-> $past(stall))
    else $error("valid outside a request");
  chk_valid_late: assert property ($rose(stall) |-> !readValid [*3])
    else $error("valid too soon after accept");
  chk_stall_last: assert property ($fell(stall) && $past(resetn) |-> readValid)
    else $error("stall dropped without last beat");
endmodule

// ### verif/ddr_native_read_port_tb_top.sv
// Bench joining host and device ends of the native read port
`timescale 1ns/100ps
module ddr_native_read_port_tb_top import ddrrp_pkg::*;;
  logic mclk, resetn, runStart, runAutoPre, memDqValid, runBusy, runDone, userValid, memCsN;
  logic [ADDR_W-1:0] runAddr;
  logic [7:0] runCount;
  logic [SIZE_W-1:0] runSize;
  logic [DATA_W-1:0] memDq, userData;
  ddrrp_cmd_t memCmd;
  logic [13:0] memAddr;
  logic [2:0] memBank;
  logic [19:0] logQ[$], expQ[$];
  int errorCnt, compares, cyc, gap, waitCnt, beats, curSize, memSeq, gotCnt, memDelay;
  ddrrp_if ddrrp_if_i();
  ddrrp_device ddrrp_device_i(.mclk(mclk), .resetn(resetn), .nat(ddrrp_if_i),
    .memCmd(memCmd), .memCsN(memCsN), .memAddr(memAddr), .memBank(memBank),
    .memDq(memDq), .memDqValid(memDqValid));
  ddrrp_host ddrrp_host_i(.mclk(mclk), .resetn(resetn), .nat(ddrrp_if_i),
    .runStart(runStart), .runAddr(runAddr), .runCount(runCount), .runSize(runSize),
    .runAutoPre(runAutoPre), .runBusy(runBusy), .runDone(runDone),
    .userValid(userValid), .userData(userData));
  ddrrp_checker ddrrp_checker_i(.mclk(mclk), .resetn(resetn),
    .reqRead(ddrrp_if_i.reqRead), .reqWrite(ddrrp_if_i.reqWrite),
    .reqAddr(ddrrp_if_i.reqAddr), .reqSize(ddrrp_if_i.reqSize),
    .autoPrechargeFlag(ddrrp_if_i.autoPrechargeFlag), .stall(ddrrp_if_i.stall),
    .readValid(ddrrp_if_i.readValid), .readDataBus(ddrrp_if_i.readDataBus));
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want) begin
      errorCnt++;
      $display("mismatch at %0t seen %0h expected %0h", $time, seen, want);
    end
  endtask
  // Verdict and end of run
  task automatic results;
    $display("compares %0d mismatches %0d", compares, errorCnt);
    if (errorCnt == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Expected memory command
  task automatic want(input ddrrp_cmd_t c, input int b, input int a);
    expQ.push_back({c, 3'(b), 14'(a)});
  endtask
  function automatic logic [ADDR_W-1:0] mk(input int r, input int b, input int c);
    return {14'(r), 3'(b), 10'(c)};
  endfunction
  // One host run, a refused start while busy, then log compare
  task automatic run(input logic [ADDR_W-1:0] a, input int n, input int s, input logic ap);
    int k;
    int g0;
    g0 = gotCnt;
    curSize = (s == 0) ? 1 : s;
    @(posedge mclk);
    runStart <= 1'b1;
    runAddr <= a;
    runCount <= 8'(n);
    runSize <= SIZE_W'(s);
    runAutoPre <= ap;
    @(posedge mclk);
    runStart <= 1'b0;
    @(posedge mclk);
    runStart <= 1'b1;
    runAddr <= 27'h0;
    @(posedge mclk);
    runStart <= 1'b0;
    k = 0;
    @(negedge mclk);
    check(32'(runBusy), 32'h1);
    while (runDone !== 1'b1 && k < 500) begin
      @(negedge mclk);
      k++;
    end
    repeat (2) @(negedge mclk);
    check(32'(k < 500), 32'h1);
    check(32'(runBusy), 32'h0);
    check(32'(runDone), 32'h0);
    check(32'(ddrrp_if_i.reqRead), 32'h0);
    check(32'(gotCnt - g0), 32'(n * curSize));
    check(32'(logQ.size()), 32'(expQ.size()));
    foreach (expQ[i]) check(32'(logQ[i]), 32'(expQ[i]));
    logQ.delete();
    expQ.delete();
    $display("test done at %0t", $time);
  endtask
  // Clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Command log, spacing, memory data model, user data check
  always @(posedge mclk) begin
    cyc++;
    gap++;
    if (cyc == 3000) begin
      errorCnt++;
      results;
    end
    if (!resetn) begin
      gap = 100;
      memDqValid <= 1'b0;
      memDq <= 32'h0;
    end else begin
      check(32'(memCsN), 32'(memCmd == CMD_NOP));
      if (memCmd != CMD_NOP) begin
        check(32'(gap >= CMD_GAP), 32'h1);
        gap = 0;
        logQ.push_back({memCmd, memBank, memAddr});
        if (memCmd inside {CMD_RD, CMD_RDA}) begin
          waitCnt = memDelay;
          beats = curSize;
        end
      end
      if (waitCnt > 0) begin
        waitCnt--;
      end else if (beats > 0) begin
        memDqValid <= 1'b1;
        memDq <= 32'hD0000000 + 32'(memSeq);
        memSeq++;
        beats--;
      end else begin
        memDqValid <= 1'b0;
        memDq <= ~memDq;
      end
      if (userValid) begin
        check(userData, 32'hD0000000 + 32'(gotCnt));
        gotCnt++;
      end
    end
  end
  // Main sequence
  initial begin
    resetn = 1'b0;
    runStart = 1'b0;
    runAddr = 27'h0;
    runCount = 8'h0;
    runSize = 6'h0;
    runAutoPre = 1'b0;
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    memDelay = 0;
    want(CMD_ACT, 2, 5);
    want(CMD_RD, 2, 8);
    want(CMD_RD, 2, 10);
    want(CMD_RD, 2, 12);
    run(mk(5, 2, 8), 3, 2, 1'b0);
    memDelay = 4;
    want(CMD_RDA, 2, 32'h414);
    run(mk(5, 2, 20), 1, 0, 1'b1);
    want(CMD_ACT, 1, 7);
    want(CMD_RD, 1, 0);
    want(CMD_RD, 1, 1);
    run(mk(7, 1, 0), 2, 1, 1'b0);
    want(CMD_PRE, 1, 0);
    want(CMD_ACT, 1, 9);
    want(CMD_RD, 1, 3);
    run(mk(9, 1, 3), 1, 4, 1'b0);
    // Start with zero requests is ignored
    @(posedge mclk);
    runStart <= 1'b1;
    runCount <= 8'h0;
    @(posedge mclk);
    runStart <= 1'b0;
    repeat (3) @(negedge mclk);
    check(32'(runBusy), 32'h0);
    check(32'(ddrrp_if_i.reqRead), 32'h0);
    check(32'(logQ.size()), 32'h0);
    $display("test done at %0t", $time);
    results;
  end
endmodule
